// ==== asp_pkg.sv ====
// How it works
// - d7 of control a drives bit clock out
// - d6 of control a drives word clock out
// - d5 floats data out between valid bits
// - d4 keeps master clocks during power down
// - d2 enables 3-d effect processing
// - mic field: off, or oversample 128/64/32
// - format field: i2s, dsp, right, left
// - word length field: 16, 20, 24, 32
// - master rate bit: continuous or 256 clocks
// - dac resync on excess group delay drift
// - adc resync on excess group delay drift
// - mute bit soft-mutes channel during resync
// - offset register delays first data bit
// - four overflow flags in bits seven to four
// - flags sticky, cleared when status is read
package asp_pkg;
  // register map
  localparam logic [7:0] ADDR_CTRL_A = 8'h08;
  localparam logic [7:0] ADDR_CTRL_B = 8'h09;
  localparam logic [7:0] ADDR_OFFSET = 8'h0a;
  localparam logic [7:0] ADDR_STATUS = 8'h0b;
  // reset values
  localparam logic [7:0] RST_CTRL_A = 8'h00;
  localparam logic [7:0] RST_CTRL_B = 8'h00;
  localparam logic [7:0] RST_OFFSET = 8'h00;
  localparam logic [3:0] RST_FLAGS = 4'h0;
  localparam logic [3:0] RST_DIVIDER = 4'h1;
  localparam logic [7:0] RDATA_UNMAPPED = 8'h00;
  // control a fields
  localparam int A_BCLK_OUT = 7;
  localparam int A_WCLK_OUT = 6;
  localparam int A_TRISTATE = 5;
  localparam int A_CLK_KEEP = 4;
  localparam int A_EFFECT3D = 2;
  localparam int A_DMIC_HI = 1;
  localparam int A_DMIC_LO = 0;
  // control b fields
  localparam int B_FMT_HI = 7;
  localparam int B_FMT_LO = 6;
  localparam int B_WL_HI = 5;
  localparam int B_WL_LO = 4;
  localparam int B_RATE256 = 3;
  localparam int B_DAC_RESYNC = 2;
  localparam int B_ADC_RESYNC = 1;
  localparam int B_RESYNC_MUTE = 0;
  // status fields
  localparam int S_FLAG_HI = 7;
  localparam int S_FLAG_LO = 4;
  localparam int S_DIV_HI = 3;
  localparam int S_DIV_LO = 0;
  // transfer formats
  localparam logic [1:0] FMT_I2S = 2'h0;
  localparam logic [1:0] FMT_DSP = 2'h1;
  localparam logic [1:0] FMT_RJF = 2'h2;
  localparam logic [1:0] FMT_LJF = 2'h3;
  // word lengths
  localparam logic [1:0] WL_16 = 2'h0;
  localparam logic [1:0] WL_20 = 2'h1;
  localparam logic [1:0] WL_24 = 2'h2;
  localparam logic [1:0] WL_32 = 2'h3;
  localparam logic [5:0] WL_BITS_16 = 6'h10;
  localparam logic [5:0] WL_BITS_20 = 6'h14;
  localparam logic [5:0] WL_BITS_24 = 6'h18;
  localparam logic [5:0] WL_BITS_32 = 6'h20;
  // digital mic codes and oversampling ratios
  localparam logic [1:0] DMIC_OFF = 2'h0;
  localparam logic [1:0] DMIC_128 = 2'h1;
  localparam logic [1:0] DMIC_64 = 2'h2;
  localparam logic [1:0] DMIC_32 = 2'h3;
  localparam logic [7:0] OSR_NONE = 8'h00;
  localparam logic [7:0] OSR_128 = 8'h80;
  localparam logic [7:0] OSR_64 = 8'h40;
  localparam logic [7:0] OSR_32 = 8'h20;
  // frame geometry
  localparam logic [8:0] FRAME_256 = 9'h100;
  localparam logic [9:0] I2S_DELAY = 10'h001;
  localparam logic [8:0] POS_MAX = 9'h1ff;
  // timing
  localparam int CLK_PERIOD_NS = 40;
  localparam int BCLK_HALF_CYC = 2;
  localparam int RESYNC_MUTE_NS = 640;
  localparam int RESYNC_MUTE_CYC =
    (RESYNC_MUTE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
endpackage

// ==== asp_sync.sv ====
`timescale 1ns/10ps
module asp_sync #(
  parameter int WIDTH = 1
) (
  // clock and reset
  input wire logic mclk_i,
  input wire logic reset_n_i,
  // async in, synced out
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] sync_o
);
  logic [WIDTH-1:0] meta_ff;
  logic [WIDTH-1:0] sync_ff;

  genvar gi;
  generate
    for (gi = 0; gi < WIDTH; gi++) begin : g_bit
      always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
          meta_ff[gi] <= 1'b0;
          sync_ff[gi] <= 1'b0;
        end else begin
          meta_ff[gi] <= async_i[gi];
          sync_ff[gi] <= meta_ff[gi];
        end
      end
    end
  endgenerate

  assign sync_o = sync_ff;
endmodule // asp_sync

// ==== asp_top.sv ====
`timescale 1ns/10ps
module asp_top
  import asp_pkg::*;
(
  // clock and reset
  input wire logic mclk_i,
  input wire logic reset_n_i,
  // register port
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  output logic [7:0] reg_rdata_o,
  // codec state and converter events
  input wire logic codec_pwr_dn_i,
  input wire logic [3:0] ovf_evt_i,
  input wire logic dac_drift_i,
  input wire logic adc_drift_i,
  // serial pins
  input wire logic bclk_i,
  output logic bclk_o,
  output logic bclk_oe_o,
  input wire logic wclk_i,
  output logic wclk_o,
  output logic wclk_oe_o,
  input wire logic din_i,
  output logic dout_o,
  output logic dout_oe_o,
  // playback samples
  input wire logic [31:0] tx_left_i,
  input wire logic [31:0] tx_right_i,
  output logic tx_take_o,
  // record samples
  output logic [31:0] rx_left_o,
  output logic [31:0] rx_right_o,
  output logic rx_valid_o,
  // configuration to the datapath
  output logic effect3d_en_o,
  output logic [7:0] dmic_osr_o,
  output logic [1:0] fmt_o,
  output logic [5:0] word_len_o,
  output logic [3:0] pll_r_o,
  // resync control
  output logic dac_resync_o,
  output logic adc_resync_o,
  output logic dac_mute_o,
  output logic adc_mute_o
);
  localparam logic [4:0] MUTE_LOAD = 5'(RESYNC_MUTE_CYC);
  localparam logic [1:0] DIV_LAST = 2'(BCLK_HALF_CYC - 1);

  function automatic logic [5:0] wl_bits(input logic [1:0] code);
    logic [5:0] r;
    r = WL_BITS_16;
    unique case (code)
      WL_16: r = WL_BITS_16;
      WL_20: r = WL_BITS_20;
      WL_24: r = WL_BITS_24;
      WL_32: r = WL_BITS_32;
    endcase
    return r;
  endfunction

  // {valid, right channel, bit index} for a frame position
  function automatic logic [6:0] win_pos(input logic [8:0] pos,
      input logic chan, input logic [1:0] fmt, input logic [7:0] off,
      input logic [5:0] wl, input logic [8:0] half);
    logic [9:0] st;
    logic [9:0] rel;
    logic [9:0] k;
    logic rt;
    logic ok;
    st = {2'h0, off};
    rt = chan;
    unique case (fmt)
      FMT_I2S: st = st + I2S_DELAY;
      FMT_LJF: st = st;
      FMT_RJF: st = st + {1'b0, half} - {4'h0, wl};
      FMT_DSP: begin
        rt = ({1'b0, pos} >= st + {4'h0, wl});
        if (rt) begin
          st = st + {4'h0, wl};
        end
      end
    endcase
    rel = {1'b0, pos} - st;
    ok = ({1'b0, pos} >= st) && (rel < {4'h0, wl});
    k = {4'h0, wl} - I2S_DELAY - rel;
    return {ok, rt, k[4:0]};
  endfunction

  // register state
  logic [7:0] ctrl_a_ff, nxt_ctrl_a;
  logic [7:0] ctrl_b_ff, nxt_ctrl_b;
  logic [7:0] offset_ff, nxt_offset;
  logic [3:0] flags_ff, nxt_flags;
  logic [3:0] div_r_ff, nxt_div_r;
  logic [7:0] rdata_ff, nxt_rdata;
  logic [5:0] wl_ff, nxt_wl;
  logic [7:0] osr_ff, nxt_osr;

  always_comb begin
    nxt_ctrl_a = ctrl_a_ff;
    nxt_ctrl_b = ctrl_b_ff;
    nxt_offset = offset_ff;
    nxt_div_r = div_r_ff;
    nxt_rdata = rdata_ff;
    nxt_flags = flags_ff;
    if (reg_wr_i) begin
      unique case (reg_addr_i)
        ADDR_CTRL_A: nxt_ctrl_a = reg_wdata_i;
        ADDR_CTRL_B: nxt_ctrl_b = reg_wdata_i;
        ADDR_OFFSET: nxt_offset = reg_wdata_i;
        ADDR_STATUS: nxt_div_r = reg_wdata_i[S_DIV_HI:S_DIV_LO];
        default: ;
      endcase
    end
    if (reg_rd_i) begin
      unique case (reg_addr_i)
        ADDR_CTRL_A: nxt_rdata = ctrl_a_ff;
        ADDR_CTRL_B: nxt_rdata = ctrl_b_ff;
        ADDR_OFFSET: nxt_rdata = offset_ff;
        ADDR_STATUS: nxt_rdata = {flags_ff, div_r_ff};
        default: nxt_rdata = RDATA_UNMAPPED;
      endcase
      if (reg_addr_i == ADDR_STATUS) begin
        nxt_flags = RST_FLAGS;
      end
    end
    nxt_flags = nxt_flags | ovf_evt_i;
    nxt_wl = wl_bits(ctrl_b_ff[B_WL_HI:B_WL_LO]);
    nxt_osr = OSR_NONE;
    unique case (ctrl_a_ff[A_DMIC_HI:A_DMIC_LO])
      DMIC_OFF: nxt_osr = OSR_NONE;
      DMIC_128: nxt_osr = OSR_128;
      DMIC_64: nxt_osr = OSR_64;
      DMIC_32: nxt_osr = OSR_32;
    endcase
  end

  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ctrl_a_ff <= RST_CTRL_A;
      ctrl_b_ff <= RST_CTRL_B;
      offset_ff <= RST_OFFSET;
      flags_ff <= RST_FLAGS;
      div_r_ff <= RST_DIVIDER;
      rdata_ff <= RDATA_UNMAPPED;
      wl_ff <= WL_BITS_16;
      osr_ff <= OSR_NONE;
    end else begin
      ctrl_a_ff <= nxt_ctrl_a;
      ctrl_b_ff <= nxt_ctrl_b;
      offset_ff <= nxt_offset;
      flags_ff <= nxt_flags;
      div_r_ff <= nxt_div_r;
      rdata_ff <= nxt_rdata;
      wl_ff <= nxt_wl;
      osr_ff <= nxt_osr;
    end
  end

  // pin synchronisers and slave edge detect
  logic [2:0] pins_s;
  logic bclk_d_ff;
  asp_sync #(.WIDTH(3)) u_sync (
    .mclk_i(mclk_i),
    .reset_n_i(reset_n_i),
    .async_i({din_i, wclk_i, bclk_i}),
    .sync_o(pins_s)
  );

  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      bclk_d_ff <= 1'b0;
    end else begin
      bclk_d_ff <= pins_s[0];
    end
  end

  // master bit clock generator
  logic [1:0] div_ff, nxt_div;
  logic bclk_gen_ff, nxt_bclk_gen;
  logic run;
  logic gen_rise;
  logic gen_fall;

  always_comb begin
    run = !codec_pwr_dn_i || ctrl_a_ff[A_CLK_KEEP];
    nxt_div = div_ff + 2'h1;
    nxt_bclk_gen = bclk_gen_ff;
    gen_rise = 1'b0;
    gen_fall = 1'b0;
    if (!run || !ctrl_a_ff[A_BCLK_OUT]) begin
      nxt_div = 2'h0;
      nxt_bclk_gen = 1'b0;
    end else if (div_ff == DIV_LAST) begin
      nxt_div = 2'h0;
      nxt_bclk_gen = !bclk_gen_ff;
      gen_rise = !bclk_gen_ff;
      gen_fall = bclk_gen_ff;
    end
  end

  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      div_ff <= 2'h0;
      bclk_gen_ff <= 1'b0;
    end else begin
      div_ff <= nxt_div;
      bclk_gen_ff <= nxt_bclk_gen;
    end
  end

  // frame engine
  logic [8:0] cpos_ff, nxt_cpos;
  logic chan_ff, nxt_chan;
  logic wprev_ff, nxt_wprev;
  logic wclk_out_ff, nxt_wclk_out;
  logic dout_ff, nxt_dout;
  logic dout_oe_ff, nxt_dout_oe;
  logic [31:0] tx_l_ff, nxt_tx_l;
  logic [31:0] tx_r_ff, nxt_tx_r;
  logic take_ff, nxt_take;
  logic [31:0] rx_l_ff, nxt_rx_l;
  logic [31:0] rx_r_ff, nxt_rx_r;
  logic [31:0] rx_lo_ff, nxt_rx_lo;
  logic [31:0] rx_ro_ff, nxt_rx_ro;
  logic rx_vld_ff, nxt_rx_vld;

  logic rise_ev;
  logic fall_ev;
  logic w_lvl;
  logic is_dsp;
  logic bound;
  logic wrap;
  logic [8:0] frame_len;
  logic [8:0] half_len;
  logic [8:0] period;
  logic [8:0] np;
  logic nchan;
  logic [6:0] rw;
  logic [6:0] tw;
  logic [31:0] src;
  logic [1:0] fmt;

  always_comb begin
    fmt = ctrl_b_ff[B_FMT_HI:B_FMT_LO];
    is_dsp = (fmt == FMT_DSP);
    rise_ev = ctrl_a_ff[A_BCLK_OUT] ? gen_rise :
              (pins_s[0] && !bclk_d_ff);
    fall_ev = ctrl_a_ff[A_BCLK_OUT] ? gen_fall :
              (!pins_s[0] && bclk_d_ff);
    w_lvl = ctrl_a_ff[A_WCLK_OUT] ? wclk_out_ff : pins_s[1];
    frame_len = {2'h0, wl_ff, 1'b0};
    if (ctrl_a_ff[A_BCLK_OUT] && ctrl_b_ff[B_RATE256]) begin
      frame_len = FRAME_256;
    end
    half_len = {1'b0, frame_len[8:1]};
    period = is_dsp ? frame_len : half_len;
    nxt_cpos = cpos_ff;
    nxt_chan = chan_ff;
    nxt_wprev = wprev_ff;
    nxt_wclk_out = wclk_out_ff;
    nxt_dout = dout_ff;
    nxt_dout_oe = dout_oe_ff;
    nxt_tx_l = tx_l_ff;
    nxt_tx_r = tx_r_ff;
    nxt_take = 1'b0;
    nxt_rx_l = rx_l_ff;
    nxt_rx_r = rx_r_ff;
    nxt_rx_lo = rx_lo_ff;
    nxt_rx_ro = rx_ro_ff;
    nxt_rx_vld = 1'b0;
    bound = is_dsp ? (w_lvl && !wprev_ff) : (w_lvl != wprev_ff);
    wrap = ({1'b0, cpos_ff} + 10'h001) >= {1'b0, period};
    np = wrap ? 9'h000 : cpos_ff + 9'h001;
    nchan = (wrap && !is_dsp) ? !chan_ff : chan_ff;
    rw = 7'h00;
    tw = win_pos(np, nchan, fmt, offset_ff, wl_ff, half_len);
    src = tw[5] ? tx_r_ff : tx_l_ff;
    // sample on rise, resync position to the word clock
    if (rise_ev) begin
      nxt_wprev = w_lvl;
      if (bound) begin
        nxt_cpos = 9'h000;
      end else if (cpos_ff != POS_MAX) begin
        nxt_cpos = cpos_ff + 9'h001;
      end
      nxt_chan = (fmt == FMT_I2S) ? w_lvl : !w_lvl;
      rw = win_pos(nxt_cpos, nxt_chan, fmt, offset_ff, wl_ff, half_len);
      if (rw[6]) begin
        if (rw[5]) begin
          nxt_rx_r[rw[4:0]] = pins_s[2];
        end else begin
          nxt_rx_l[rw[4:0]] = pins_s[2];
        end
        if (rw[5] && rw[4:0] == 5'h00) begin
          nxt_rx_lo = rx_l_ff;
          nxt_rx_ro = nxt_rx_r;
          nxt_rx_vld = 1'b1;
        end
      end
    end
    // drive on fall for the predicted next position
    if (fall_ev) begin
      if (np == 9'h000 && (is_dsp || !nchan)) begin
        nxt_tx_l = tx_left_i;
        nxt_tx_r = tx_right_i;
        nxt_take = 1'b1;
        src = tw[5] ? tx_right_i : tx_left_i;
      end
      nxt_dout = tw[6] && src[tw[4:0]];
      nxt_dout_oe = tw[6] || !ctrl_a_ff[A_TRISTATE];
      if (ctrl_a_ff[A_WCLK_OUT]) begin
        unique case (fmt)
          FMT_I2S: nxt_wclk_out = nchan;
          FMT_DSP: nxt_wclk_out = (np == 9'h000);
          FMT_RJF: nxt_wclk_out = !nchan;
          FMT_LJF: nxt_wclk_out = !nchan;
        endcase
      end
    end
    if (!ctrl_a_ff[A_TRISTATE]) begin
      nxt_dout_oe = 1'b1;
    end
  end

  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      cpos_ff <= 9'h000;
      chan_ff <= 1'b0;
      wprev_ff <= 1'b0;
      wclk_out_ff <= 1'b0;
      dout_ff <= 1'b0;
      dout_oe_ff <= 1'b1;
      tx_l_ff <= 32'h0000_0000;
      tx_r_ff <= 32'h0000_0000;
      take_ff <= 1'b0;
      rx_l_ff <= 32'h0000_0000;
      rx_r_ff <= 32'h0000_0000;
      rx_lo_ff <= 32'h0000_0000;
      rx_ro_ff <= 32'h0000_0000;
      rx_vld_ff <= 1'b0;
    end else begin
      cpos_ff <= nxt_cpos;
      chan_ff <= nxt_chan;
      wprev_ff <= nxt_wprev;
      wclk_out_ff <= nxt_wclk_out;
      dout_ff <= nxt_dout;
      dout_oe_ff <= nxt_dout_oe;
      tx_l_ff <= nxt_tx_l;
      tx_r_ff <= nxt_tx_r;
      take_ff <= nxt_take;
      rx_l_ff <= nxt_rx_l;
      rx_r_ff <= nxt_rx_r;
      rx_lo_ff <= nxt_rx_lo;
      rx_ro_ff <= nxt_rx_ro;
      rx_vld_ff <= nxt_rx_vld;
    end
  end

  // converter resync, index 0 dac, 1 adc
  logic [1:0] rs_ff, nxt_rs;
  logic [1:0] mute_ff, nxt_mute;
  logic [4:0] mcnt_ff [2];
  logic [4:0] nxt_mcnt [2];
  logic [1:0] drift;
  logic [1:0] rs_en;

  always_comb begin
    drift = {adc_drift_i, dac_drift_i};
    rs_en = {ctrl_b_ff[B_ADC_RESYNC], ctrl_b_ff[B_DAC_RESYNC]};
    for (int i = 0; i < 2; i++) begin
      nxt_rs[i] = drift[i] && rs_en[i];
      nxt_mcnt[i] = mcnt_ff[i];
      if (nxt_rs[i] && ctrl_b_ff[B_RESYNC_MUTE]) begin
        nxt_mcnt[i] = MUTE_LOAD;
      end else if (mcnt_ff[i] != 5'h00) begin
        nxt_mcnt[i] = mcnt_ff[i] - 5'h01;
      end
      nxt_mute[i] = (nxt_mcnt[i] != 5'h00);
    end
  end

  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rs_ff <= 2'h0;
      mute_ff <= 2'h0;
      mcnt_ff[0] <= 5'h00;
      mcnt_ff[1] <= 5'h00;
    end else begin
      rs_ff <= nxt_rs;
      mute_ff <= nxt_mute;
      mcnt_ff[0] <= nxt_mcnt[0];
      mcnt_ff[1] <= nxt_mcnt[1];
    end
  end

  assign reg_rdata_o = rdata_ff;
  assign bclk_o = bclk_gen_ff;
  assign bclk_oe_o = ctrl_a_ff[A_BCLK_OUT];
  assign wclk_o = wclk_out_ff;
  assign wclk_oe_o = ctrl_a_ff[A_WCLK_OUT];
  assign dout_o = dout_ff;
  assign dout_oe_o = dout_oe_ff;
  assign tx_take_o = take_ff;
  assign rx_left_o = rx_lo_ff;
  assign rx_right_o = rx_ro_ff;
  assign rx_valid_o = rx_vld_ff;
  assign effect3d_en_o = ctrl_a_ff[A_EFFECT3D];
  assign dmic_osr_o = osr_ff;
  assign fmt_o = ctrl_b_ff[B_FMT_HI:B_FMT_LO];
  assign word_len_o = wl_ff;
  assign pll_r_o = div_r_ff;
  assign dac_resync_o = rs_ff[0];
  assign adc_resync_o = rs_ff[1];
  assign dac_mute_o = mute_ff[0];
  assign adc_mute_o = mute_ff[1];
endmodule // asp_top

// ==== asp_checker_sva.sv ====
`timescale 1ns/10ps
module asp_checker
  import asp_pkg::*;
(
  // clock and reset
  input wire logic mclk_i,
  input wire logic reset_n_i,
  // register port
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic [7:0] reg_rdata_o,
  // state and events
  input wire logic codec_pwr_dn_i,
  input wire logic dac_drift_i,
  // watched outputs
  input wire logic bclk_o,
  input wire logic bclk_oe_o,
  input wire logic wclk_oe_o,
  input wire logic dout_oe_o,
  input wire logic [7:0] dmic_osr_o,
  input wire logic [5:0] word_len_o,
  input wire logic [3:0] pll_r_o,
  input wire logic dac_resync_o,
  input wire logic dac_mute_o
);
  localparam logic [7:0] OSR_T [4] = '{OSR_NONE, OSR_128, OSR_64, OSR_32};
  localparam logic [5:0] WL_T [4] = '{WL_BITS_16, WL_BITS_20, WL_BITS_24,
    WL_BITS_32};
  logic [7:0] sh_a_ff;
  logic [7:0] sh_b_ff;
  logic [1:0] q_ff;
  logic quiet;
  // quiet: no register write in the last three cycles
  assign quiet = q_ff == 2'h3;
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      sh_a_ff <= RST_CTRL_A;
      sh_b_ff <= RST_CTRL_B;
      q_ff <= 2'h3;
    end else begin
      if (reg_wr_i && reg_addr_i == ADDR_CTRL_A) sh_a_ff <= reg_wdata_i;
      if (reg_wr_i && reg_addr_i == ADDR_CTRL_B) sh_b_ff <= reg_wdata_i;
      q_ff <= reg_wr_i ? 2'h0 : (quiet ? q_ff : q_ff + 2'h1);
    end
  end
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!reset_n_i);
  property p_bclk_dir;
    quiet |-> bclk_oe_o == sh_a_ff[A_BCLK_OUT];
  endproperty
  a_bclk_dir: assert property (p_bclk_dir)
    else $error("bit clock drive differs from control");
  property p_wclk_dir;
    quiet |-> wclk_oe_o == sh_a_ff[A_WCLK_OUT];
  endproperty
  a_wclk_dir: assert property (p_wclk_dir)
    else $error("word clock drive differs from control");
  property p_drive;
    quiet && !sh_a_ff[A_TRISTATE] |-> dout_oe_o;
  endproperty
  a_drive: assert property (p_drive)
    else $error("data out released while tristate off");
  property p_clk_stop;
    (codec_pwr_dn_i && !sh_a_ff[A_CLK_KEEP] && quiet) [*6] |-> !bclk_o;
  endproperty
  a_clk_stop: assert property (p_clk_stop)
    else $error("bit clock runs in power down");
  property p_osr;
    quiet |-> dmic_osr_o == OSR_T[sh_a_ff[A_DMIC_HI:A_DMIC_LO]];
  endproperty
  a_osr: assert property (p_osr)
    else $error("mic oversampling ratio wrong");
  property p_wlen;
    quiet |-> word_len_o == WL_T[sh_b_ff[B_WL_HI:B_WL_LO]];
  endproperty
  a_wlen: assert property (p_wlen)
    else $error("word length wrong");
  property p_half;
    $rose(bclk_o) && !codec_pwr_dn_i ##1 !codec_pwr_dn_i &&
      sh_a_ff[A_BCLK_OUT] |-> bclk_o ##1 !bclk_o;
  endproperty
  a_half: assert property (p_half)
    else $error("bit clock half period wrong");
  property p_div_keep;
    reg_rd_i && reg_addr_i == ADDR_STATUS |=> reg_rdata_o[3:0] == pll_r_o;
  endproperty
  a_div_keep: assert property (p_div_keep)
    else $error("status read lost divider field");
  property p_resync;
    dac_drift_i && quiet |=> dac_resync_o == $past(sh_b_ff[B_DAC_RESYNC]);
  endproperty
  a_resync: assert property (p_resync)
    else $error("dac resync pulse wrong");
  property p_mute;
    dac_resync_o && quiet && sh_b_ff[B_RESYNC_MUTE] |-> ##[1:2]
      dac_mute_o [*8];
  endproperty
  a_mute: assert property (p_mute)
    else $error("dac not muted during resync");
  c_status: cover property (reg_rd_i && reg_addr_i == ADDR_STATUS);
  c_mute: cover property (dac_resync_o ##2 dac_mute_o);
  c_stop: cover property ((codec_pwr_dn_i && !bclk_o) [*6]);
endmodule // asp_checker
bind asp_top asp_checker i_asp_checker (.mclk_i, .reset_n_i, .reg_wr_i,
  .reg_rd_i, .reg_addr_i, .reg_wdata_i, .reg_rdata_o, .codec_pwr_dn_i,
  .dac_drift_i, .bclk_o, .bclk_oe_o, .wclk_oe_o, .dout_oe_o, .dmic_osr_o,
  .word_len_o, .pll_r_o, .dac_resync_o, .dac_mute_o);

// ==== asp_host_model.sv ====
`timescale 1ns/10ps
module asp_host_model (
  // frame control
  input wire logic run_i,
  input wire logic [31:0] left_i,
  input wire logic [31:0] right_i,
  // host side pins
  output logic bclk_o,
  output logic wclk_o,
  output logic din_o
);
  logic [31:0] word;
  initial begin
    bclk_o = 1'b0;
    wclk_o = 1'b0;
    din_o = 1'b0;
    forever begin
      wait (run_i);
      #13;
      // left justified, 16 bits, offset zero
      for (int ch = 0; ch < 2; ch++) begin
        wclk_o = ch == 0;
        word = ch == 0 ? left_i : right_i;
        for (int b = 15; b >= 0; b--) begin
          din_o = word[b];
          #160 bclk_o = 1'b1;
          #160 bclk_o = 1'b0;
        end
      end
      // no stale level once the frame is over
      din_o = ~din_o;
    end
  end
endmodule // asp_host_model

// ==== asp_top_bench.sv ====
`timescale 1ns/10ps
module asp_top_bench;
  import asp_pkg::*;
  localparam logic [7:0] RST_T [4] = '{RST_CTRL_A, RST_CTRL_B, RST_OFFSET,
    {RST_FLAGS, RST_DIVIDER}};
  localparam logic [7:0] RSY_T [3] = '{8'h07, 8'h06, 8'h02};
  logic mclk_i = 1'b0;
  logic reset_n_i, reg_wr_i, reg_rd_i, codec_pwr_dn_i, dac_drift_i;
  logic adc_drift_i, bclk_i, wclk_i, din_i, bclk_o, bclk_oe_o, wclk_o;
  logic wclk_oe_o, dout_o, dout_oe_o, tx_take_o, rx_valid_o, effect3d_en_o;
  logic dac_resync_o, adc_resync_o, dac_mute_o, adc_mute_o;
  logic [7:0] reg_addr_i, reg_wdata_i, reg_rdata_o, dmic_osr_o, d, a, b, o;
  logic [3:0] ovf_evt_i, pll_r_o, e1, e2;
  logic [31:0] tx_left_i, tx_right_i, rx_left_o, rx_right_o, v, dw, ww;
  logic [31:0] host_l, host_r;
  logic [1:0] fmt_o;
  logic [5:0] word_len_o;
  logic host_run, h_bclk, h_wclk, h_din;
  int seed, failures, tests_run, cyc, n;
  assign bclk_i = bclk_oe_o ? bclk_o : h_bclk;
  assign wclk_i = wclk_oe_o ? wclk_o : h_wclk;
  assign din_i = h_din;
  asp_top i_asp_top (.mclk_i, .reset_n_i, .reg_wr_i, .reg_rd_i, .reg_addr_i,
    .reg_wdata_i, .reg_rdata_o, .codec_pwr_dn_i, .ovf_evt_i, .dac_drift_i,
    .adc_drift_i, .bclk_i, .bclk_o, .bclk_oe_o, .wclk_i, .wclk_o, .wclk_oe_o,
    .din_i, .dout_o, .dout_oe_o, .tx_left_i, .tx_right_i, .tx_take_o,
    .rx_left_o, .rx_right_o, .rx_valid_o, .effect3d_en_o, .dmic_osr_o,
    .fmt_o, .word_len_o, .pll_r_o, .dac_resync_o, .adc_resync_o, .dac_mute_o,
    .adc_mute_o);
  asp_host_model i_asp_host_model (.run_i(host_run), .left_i(host_l),
    .right_i(host_r), .bclk_o(h_bclk), .wclk_o(h_wclk), .din_o(h_din));
  always #20 mclk_i = ~mclk_i;
  always @(posedge mclk_i) begin
    cyc++;
    if (cyc == 30000) begin
      failures++;
      end_sim;
    end
  end
  task automatic end_sim;
    $display("failures=%0d tests_run=%0d", failures, tests_run);
    if (failures == 0 && tests_run > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tick(input int k);
    repeat (k) @(posedge mclk_i);
    #2;
  endtask
  task automatic wr(input logic [7:0] ad, input logic [7:0] dt);
    tick(1);
    reg_wr_i = 1'b1;
    reg_addr_i = ad;
    reg_wdata_i = dt;
    tick(1);
    reg_wr_i = 1'b0;
  endtask
  task automatic rd(input logic [7:0] ad, output logic [7:0] dt);
    tick(1);
    reg_rd_i = 1'b1;
    reg_addr_i = ad;
    tick(1);
    reg_rd_i = 1'b0;
    dt = reg_rdata_o;
  endtask
  // wait for a take (0) or receive (1) pulse, at least one edge on
  task automatic wait_pulse(input bit rx);
    int k;
    k = 0;
    do begin
      @(posedge mclk_i);
      #1;
      k++;
    end while ((rx ? rx_valid_o : tx_take_o) !== 1'b1 && k < 3000);
    chk(32'(k < 3000), 32'h0000_0001);
  endtask
  // bit clock rises and released data cycles over one frame
  task automatic frame(input int exp_n, input bit gaps);
    int r, lo;
    logic pb;
    r = 0;
    lo = 0;
    wait_pulse(1'b0);
    pb = bclk_o;
    do begin
      @(posedge mclk_i);
      #1;
      r += int'(bclk_o && !pb);
      pb = bclk_o;
      lo += int'(dout_oe_o !== 1'b1);
    end while (tx_take_o !== 1'b1 && r < 600);
    chk(32'(r), 32'(exp_n));
    chk(32'(lo > 0), 32'(gaps));
  endtask
  task automatic rises(output int r);
    tick(8);
    r = 0;
    repeat (40) @(posedge bclk_o or posedge mclk_i) r += int'(bclk_o);
    r = r > 0;
    #2;
  endtask
  function automatic logic [7:0] exp_osr(input logic [1:0] c);
    return c == DMIC_OFF ? OSR_NONE : (c == DMIC_128 ? OSR_128 :
      (c == DMIC_64 ? OSR_64 : OSR_32));
  endfunction
  function automatic logic [5:0] exp_wl(input logic [1:0] c);
    return c == WL_16 ? WL_BITS_16 : (c == WL_20 ? WL_BITS_20 :
      (c == WL_24 ? WL_BITS_24 : WL_BITS_32));
  endfunction
  initial begin
    seed = 87374;
    {reg_wr_i, reg_rd_i, codec_pwr_dn_i, dac_drift_i, adc_drift_i} = 5'h00;
    {reg_addr_i, reg_wdata_i, ovf_evt_i, host_run} = 21'h00_0000;
    {tx_left_i, tx_right_i, host_l, host_r} = 128'h0;
    reset_n_i = 1'b0;
    tick(12);
    reset_n_i = 1'b1;
    for (int i = 0; i < 4; i++) begin
      rd(ADDR_CTRL_A + 8'(i), d);
      chk(32'(d), 32'(RST_T[i]));
    end
    rd(8'h0c, d);
    chk(32'(d), 32'(RDATA_UNMAPPED));
    for (int i = 0; i < 4; i++) begin
      v = $random(seed);
      a = {v[7:4], 1'b0, v[2], 2'(i)};
      b = {2'(i), 2'(i), v[3:0]};
      o = {4'h0, v[11:8]};
      wr(ADDR_CTRL_A, a);
      wr(ADDR_CTRL_B, b);
      wr(ADDR_OFFSET, o);
      rd(ADDR_CTRL_A, d);
      chk(32'(d), 32'(a));
      rd(ADDR_CTRL_B, d);
      chk(32'(d), 32'(b));
      rd(ADDR_OFFSET, d);
      chk(32'(d), 32'(o));
      chk(32'(dmic_osr_o), 32'(exp_osr(2'(i))));
      chk(32'(word_len_o), 32'(exp_wl(2'(i))));
      chk(32'(fmt_o), 32'(i));
      chk(32'({effect3d_en_o, bclk_oe_o}), 32'({a[2], a[7]}));
    end
    wr(ADDR_STATUS, 8'hf5);
    rd(ADDR_STATUS, d);
    chk(32'(d), 32'h0000_0005);
    chk(32'(pll_r_o), 32'h0000_0005);
    v = $random(seed);
    {e1, e2} = v[7:0];
    ovf_evt_i = e1;
    tick(1);
    ovf_evt_i = e2 | 4'h1;
    tick(1);
    ovf_evt_i = 4'h0;
    tick(3);
    rd(ADDR_STATUS, d);
    chk(32'(d), 32'({e1 | e2 | 4'h1, 4'h5}));
    rd(ADDR_STATUS, d);
    chk(32'(d), 32'h0000_0005);
    // event and read clear in one cycle: the event wins
    tick(1);
    {reg_rd_i, ovf_evt_i} = 5'h18;
    reg_addr_i = ADDR_STATUS;
    tick(1);
    {reg_rd_i, ovf_evt_i} = 5'h00;
    chk(32'(reg_rdata_o), 32'h0000_0005);
    rd(ADDR_STATUS, d);
    chk(32'(d), 32'h0000_0085);
    foreach (RSY_T[i]) begin
      wr(ADDR_CTRL_B, RSY_T[i]);
      // quiet bus so the resync checks are armed
      tick(3);
      {dac_drift_i, adc_drift_i} = 2'h3;
      tick(1);
      {dac_drift_i, adc_drift_i} = 2'h0;
      b = RSY_T[i];
      chk(32'({dac_resync_o, adc_resync_o}), 32'(b[2:1]));
      tick(3);
      chk(32'({dac_mute_o, adc_mute_o}), 32'(b[2:1] & {2{b[0]}}));
      tick(20);
    end
    tx_left_i = $random(seed);
    tx_right_i = $random(seed);
    wr(ADDR_CTRL_A, 8'hc0);
    wr(ADDR_CTRL_B, 8'hc0);
    wr(ADDR_OFFSET, 8'h00);
    frame(32, 1'b0);
    wait_pulse(1'b0);
    for (int k = 31; k >= 0; k--) begin
      @(posedge bclk_o);
      dw[k] = dout_o;
      ww[k] = wclk_o;
    end
    chk(dw, {tx_left_i[15:0], tx_right_i[15:0]});
    chk(ww, 32'hffff_0000);
    wr(ADDR_CTRL_A, 8'he0);
    wr(ADDR_CTRL_B, 8'hc8);
    frame(256, 1'b1);
    wr(ADDR_CTRL_A, 8'hc0);
    codec_pwr_dn_i = 1'b1;
    rises(n);
    chk(32'(n), 32'h0000_0000);
    wr(ADDR_CTRL_A, 8'hd0);
    rises(n);
    chk(32'(n), 32'h0000_0001);
    codec_pwr_dn_i = 1'b0;
    wr(ADDR_CTRL_A, 8'h00);
    wr(ADDR_CTRL_B, 8'hc0);
    host_l = $random(seed);
    host_r = $random(seed);
    host_run = 1'b1;
    wait_pulse(1'b1);
    wait_pulse(1'b1);
    chk({rx_left_o[15:0], rx_right_o[15:0]}, {host_l[15:0],
      host_r[15:0]});
    host_run = 1'b0;
    end_sim;
  end
endmodule // asp_top_bench
